// ===== logic/tmr8_ctrl.sv
// 8-bit timer/counter control, compare and interrupt registers on AHB-Lite
// Function
// RULE1: Force strobes act only in non-PWM waveform modes.
// RULE2: Software writes force strobes as zero in PWM modes.
// RULE3: Force strobe causes immediate match; pin follows channel output mode.
// RULE4: Forced match sets no flag, no interrupt, no counter clear.
// RULE5: Force strobes are not stored and read zero.
// RULE6: Reserved bits of control B, enable and flag registers read zero.
// RULE7: Clock select: stop, undivided, divide by 8, 64, 256, 1024.
// RULE8: Select 110 counts falling, 111 rising edges of count input.
// RULE9: Count input edges count even when the pin is an output.
// RULE10: Software reads and writes the counter at any time.
// RULE11: Counter write blocks compare match on next timer tick.
// RULE12: Both compare registers compared continuously; match drives flag, pin. In PWM modes a match here sets only the flag; the pins hold.
// RULE13: Interrupt taken when mask bit, global enable and flag set.
// RULE14: Counter match sets compare A or compare B flag.
// RULE15: Flag cleared by hardware when its vector is executed.
// RULE16: Writing one clears a flag; writing zero leaves it.
// RULE17: Overflow sets overflow flag; point depends on waveform mode.
// RULE18: Overflow at MAX, at BOTTOM in phase-correct, at TOP fast-OCA.
// RULE19: Non-PWM output modes: off, toggle, clear, set.
// RULE20: Clock select zero holds counter and produces no counting events.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module tmr8_ctrl
    import tmr8_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic count_input_pin,
    input wire logic [2:0] vector_ack,
    output tmr8_wave_s wave_out,
    output logic [2:0] irq_req
);
    // Register state
    tmr8_ctrl_a_s ctrl_a_r;
    logic wave_mode_high_bit_r;
    logic [2:0] clock_select_field_r;
    logic [7:0] timer_count_value_r;
    logic [7:0] compare_value_a_r;
    logic [7:0] compare_value_b_r;
    logic [2:0] timer_irq_enable_r;
    logic [2:0] timer_irq_flags_r;
    logic global_irq_en_r;
    logic [9:0] presc_r;
    logic pin_d_r;
    logic up_r;
    logic blank_r;
    logic oa_r;
    logic ob_r;
    // Bus address phase capture
    logic wr_ph_r;
    logic rd_ph_r;
    logic [7:0] addr_r;

    tmr8_wgm_e wgm;
    logic addr_ok;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_cnt;
    logic wr_en;
    logic wr_flg;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_glb;
    logic tick;
    logic pwm_mode;
    logic phase_mode;
    logic [7:0] top_val;
    logic [7:0] cnt_nxt;
    logic up_nxt;
    logic match_a;
    logic match_b;
    logic ovf_ev;
    logic force_a;
    logic force_b;

    // Decode a mapped word offset; used by the address phase
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == TMR8_OFS_CTRL_A) || (a == TMR8_OFS_CTRL_B)
            || (a == TMR8_OFS_COUNT) || (a == TMR8_OFS_CMP_A)
            || (a == TMR8_OFS_CMP_B) || (a == TMR8_OFS_IRQ_EN)
            || (a == TMR8_OFS_IRQ_FLG) || (a == TMR8_OFS_GLOBAL);
    endfunction

    // Non-PWM output action on a match
    function automatic logic pin_act(input logic [1:0] m, input logic cur);
        unique case (m)
            TMR8_COM_TOGGLE: pin_act = ~cur;
            TMR8_COM_CLEAR: pin_act = 1'b0;
            TMR8_COM_SET: pin_act = 1'b1;
            default: pin_act = cur;
        endcase
    endfunction

    assign hreadyout = 1'b1; // Zero wait states, always OKAY
    assign hresp = 1'b0;
    assign addr_ok = haddr[31:8] == 24'h000000 && mapped(haddr[7:0]);

    // Address phase capture; writes only when word-sized to mapped offsets, reads of any size or offset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            addr_r <= TMR8_RST_BYTE;
        end
        else if (hready)
        begin
            wr_ph_r <= hsel && htrans == TMR8_HTRANS_NONSEQ && hwrite
                && hsize == TMR8_HSIZE_WORD && addr_ok;
            rd_ph_r <= hsel && htrans == TMR8_HTRANS_NONSEQ && !hwrite;
            addr_r <= haddr[7:0];
        end
    end

    assign wr_ctrl_a = wr_ph_r && addr_r == TMR8_OFS_CTRL_A;
    assign wr_ctrl_b = wr_ph_r && addr_r == TMR8_OFS_CTRL_B;
    assign wr_cnt = wr_ph_r && addr_r == TMR8_OFS_COUNT;
    assign wr_cmp_a = wr_ph_r && addr_r == TMR8_OFS_CMP_A;
    assign wr_cmp_b = wr_ph_r && addr_r == TMR8_OFS_CMP_B;
    assign wr_en = wr_ph_r && addr_r == TMR8_OFS_IRQ_EN;
    assign wr_flg = wr_ph_r && addr_r == TMR8_OFS_IRQ_FLG;
    assign wr_glb = wr_ph_r && addr_r == TMR8_OFS_GLOBAL;

    // Read mux; strobes and reserved bits return zero
    always_comb
    begin
        hrdata = 32'h00000000;
        unique case (addr_r)
            TMR8_OFS_CTRL_A: hrdata[7:0] = ctrl_a_r;
            TMR8_OFS_CTRL_B: hrdata[3:0] =
                {wave_mode_high_bit_r, clock_select_field_r}; // RULE5 RULE6
            TMR8_OFS_COUNT: hrdata[7:0] = timer_count_value_r; // RULE10
            TMR8_OFS_CMP_A: hrdata[7:0] = compare_value_a_r;
            TMR8_OFS_CMP_B: hrdata[7:0] = compare_value_b_r;
            TMR8_OFS_IRQ_EN: hrdata[2:0] = timer_irq_enable_r; // RULE6
            TMR8_OFS_IRQ_FLG: hrdata[2:0] = timer_irq_flags_r; // RULE6
            TMR8_OFS_GLOBAL: hrdata[0] = global_irq_en_r;
            default: hrdata = 32'h00000000;
        endcase
        if (!rd_ph_r)
            hrdata = 32'h00000000;
    end

    // Plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_a_r <= TMR8_RST_BYTE;
            wave_mode_high_bit_r <= 1'b0;
            clock_select_field_r <= TMR8_CS_STOP;
            compare_value_a_r <= TMR8_RST_BYTE;
            compare_value_b_r <= TMR8_RST_BYTE;
            timer_irq_enable_r <= 3'h0;
            global_irq_en_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a_r <= {hwdata[7:4], 2'b00, hwdata[1:0]};
            if (wr_ctrl_b)
            begin
                wave_mode_high_bit_r <= hwdata[TMR8_WGM_HI_BIT];
                clock_select_field_r <= hwdata[2:0];
            end
            if (wr_cmp_a)
                compare_value_a_r <= hwdata[7:0];
            if (wr_cmp_b)
                compare_value_b_r <= hwdata[7:0];
            if (wr_en)
                timer_irq_enable_r <= hwdata[2:0];
            if (wr_glb)
                global_irq_en_r <= hwdata[0];
        end
    end

    assign wgm = tmr8_wgm_e'({wave_mode_high_bit_r,
        ctrl_a_r.wave_mode_low});
    assign pwm_mode = wgm == TMR8_WGM_PC_FF || wgm == TMR8_WGM_FAST_FF
        || wgm == TMR8_WGM_PC_OCA || wgm == TMR8_WGM_FAST_OCA;
    assign phase_mode = wgm == TMR8_WGM_PC_FF || wgm == TMR8_WGM_PC_OCA;
    assign top_val = (wgm == TMR8_WGM_CTC || wgm == TMR8_WGM_PC_OCA
        || wgm == TMR8_WGM_FAST_OCA) ? compare_value_a_r : TMR8_MAX;

    // Free-running prescaler and count-input edge memory
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            presc_r <= TMR8_RST_PRE;
            pin_d_r <= 1'b0;
        end
        else
        begin
            presc_r <= presc_r + 10'h001;
            pin_d_r <= count_input_pin; // RULE9
        end
    end

    // Timer clock select; the pin is read directly so direction is moot
    always_comb
    begin
        unique case (clock_select_field_r)
            TMR8_CS_STOP: tick = 1'b0; // RULE20
            TMR8_CS_DIV1: tick = 1'b1; // RULE7
            TMR8_CS_DIV8: tick = (presc_r & TMR8_DIV8_MASK) == TMR8_RST_PRE;
            TMR8_CS_DIV64: tick = (presc_r & TMR8_DIV64_MASK) == TMR8_RST_PRE;
            TMR8_CS_DIV256:
                tick = (presc_r & TMR8_DIV256_MASK) == TMR8_RST_PRE;
            TMR8_CS_DIV1024:
                tick = (presc_r & TMR8_DIV1024_MASK) == TMR8_RST_PRE;
            TMR8_CS_EXT_FALL: tick = pin_d_r && !count_input_pin; // RULE8
            default: tick = !pin_d_r && count_input_pin; // RULE8 RULE9
        endcase
    end

    // Matches, continuous compare; blanked on first tick after a counter write
    assign match_a = tick && !blank_r
        && timer_count_value_r == compare_value_a_r; // RULE11 RULE12
    assign match_b = tick && !blank_r
        && timer_count_value_r == compare_value_b_r; // RULE11 RULE12

    // Next count and direction for the waveform mode
    always_comb
    begin
        cnt_nxt = timer_count_value_r + 8'h01;
        up_nxt = up_r;
        ovf_ev = 1'b0;
        if (phase_mode)
        begin
            if (up_r && timer_count_value_r >= top_val)
            begin
                cnt_nxt = timer_count_value_r - 8'h01;
                up_nxt = 1'b0;
            end
            else if (!up_r && timer_count_value_r == TMR8_BOTTOM)
            begin
                cnt_nxt = timer_count_value_r + 8'h01;
                up_nxt = 1'b1;
                ovf_ev = 1'b1; // RULE18
            end
            else if (!up_r)
                cnt_nxt = timer_count_value_r - 8'h01;
        end
        else if (wgm == TMR8_WGM_FAST_OCA)
        begin
            if (timer_count_value_r == top_val)
            begin
                cnt_nxt = TMR8_BOTTOM;
                ovf_ev = 1'b1; // RULE18
            end
        end
        else
        begin
            // Only the counter's own match clears it in CLEAR_ON_MATCH_MODE, never a force
            if (wgm == TMR8_WGM_CTC && timer_count_value_r == top_val)
                cnt_nxt = TMR8_BOTTOM; // RULE4
            ovf_ev = timer_count_value_r == TMR8_MAX; // RULE17 RULE18
        end
    end

    // Counter: software write wins over counting
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_count_value_r <= TMR8_RST_BYTE;
            up_r <= 1'b1;
            blank_r <= 1'b0;
        end
        else if (wr_cnt)
        begin
            timer_count_value_r <= hwdata[7:0]; // RULE10
            blank_r <= 1'b1; // RULE11
        end
        else if (tick)
        begin
            timer_count_value_r <= cnt_nxt;
            up_r <= up_nxt;
            blank_r <= 1'b0;
        end
    end

    // Force strobes: never stored, gated off in PWM modes
    assign force_a = wr_ctrl_b && hwdata[TMR8_FOC_A_BIT] && !pwm_mode; // RULE1
    assign force_b = wr_ctrl_b && hwdata[TMR8_FOC_B_BIT] && !pwm_mode; // RULE1

    // Waveform pins; PWM shaping is outside this block, non-PWM only here
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oa_r <= 1'b0;
            ob_r <= 1'b0;
        end
        else if (!pwm_mode)
        begin
            if (force_a || match_a)
                oa_r <= pin_act(ctrl_a_r.out_mode_a_field, oa_r); // RULE3 RULE19
            if (force_b || match_b)
                ob_r <= pin_act(ctrl_a_r.out_mode_b_field, ob_r); // RULE3 RULE19
        end
    end

    assign wave_out.wave_out_a_pin = oa_r;
    assign wave_out.wave_out_b_pin = ob_r;
    assign wave_out.wave_out_a_oe = ctrl_a_r.out_mode_a_field != TMR8_COM_OFF;
    assign wave_out.wave_out_b_oe = ctrl_a_r.out_mode_b_field != TMR8_COM_OFF;

    // Flags: set wins over software and vector clears; forces never set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            timer_irq_flags_r <= 3'h0;
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if ((wr_flg && hwdata[i]) || vector_ack[i]) // RULE15 RULE16
                    timer_irq_flags_r[i] <= 1'b0;
            end
            if (match_b)
                timer_irq_flags_r[TMR8_CMPB_BIT] <= 1'b1; // RULE14 RULE4
            if (match_a)
                timer_irq_flags_r[TMR8_CMPA_BIT] <= 1'b1; // RULE14 RULE4
            if (tick && ovf_ev)
                timer_irq_flags_r[TMR8_OVF_BIT] <= 1'b1; // RULE17 RULE20
        end
    end

    // Per-source requests to the interrupt controller
    assign irq_req = timer_irq_flags_r & timer_irq_enable_r
        & {3{global_irq_en_r}}; // RULE13
endmodule

// ===== logic/tmr8_pkg.sv
// Package for the 8-bit timer control block: register map, fields, encodings
package tmr8_pkg;
    // Register byte addresses (one aligned word each)
    localparam logic [7:0] TMR8_OFS_CTRL_A = 8'h00;
    localparam logic [7:0] TMR8_OFS_CTRL_B = 8'h04;
    localparam logic [7:0] TMR8_OFS_COUNT = 8'h08;
    localparam logic [7:0] TMR8_OFS_CMP_A = 8'h0C;
    localparam logic [7:0] TMR8_OFS_CMP_B = 8'h10;
    localparam logic [7:0] TMR8_OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] TMR8_OFS_IRQ_FLG = 8'h18;
    localparam logic [7:0] TMR8_OFS_GLOBAL = 8'h1C;
    // Control B field positions
    localparam int TMR8_FOC_A_BIT = 7;
    localparam int TMR8_FOC_B_BIT = 6;
    localparam int TMR8_WGM_HI_BIT = 3;
    // Flag / enable bit positions
    localparam int TMR8_CMPB_BIT = 2;
    localparam int TMR8_CMPA_BIT = 1;
    localparam int TMR8_OVF_BIT = 0;
    // Reset values
    localparam logic [7:0] TMR8_RST_BYTE = 8'h00;
    localparam logic [9:0] TMR8_RST_PRE = 10'h000;
    // Fixed counter limits
    localparam logic [7:0] TMR8_MAX = 8'hFF;
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    // Prescaler tap masks (count mod N == 0 gives one tick)
    localparam logic [9:0] TMR8_DIV8_MASK = 10'h007;
    localparam logic [9:0] TMR8_DIV64_MASK = 10'h03F;
    localparam logic [9:0] TMR8_DIV256_MASK = 10'h0FF;
    localparam logic [9:0] TMR8_DIV1024_MASK = 10'h3FF;
    // Clock select encodings
    localparam logic [2:0] TMR8_CS_STOP = 3'h0;
    localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
    // Output mode encodings (non-PWM)
    localparam logic [1:0] TMR8_COM_OFF = 2'h0;
    localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR8_COM_CLEAR = 2'h2;
    localparam logic [1:0] TMR8_COM_SET = 2'h3;
    // AHB encodings
    localparam logic [1:0] TMR8_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] TMR8_HSIZE_WORD = 3'h2;

    // Waveform generation modes
    typedef enum logic [2:0] {
        TMR8_WGM_NORMAL = 3'h0,
        TMR8_WGM_PC_FF = 3'h1,
        TMR8_WGM_CTC = 3'h2,
        TMR8_WGM_FAST_FF = 3'h3,
        TMR8_WGM_RSV4 = 3'h4,
        TMR8_WGM_PC_OCA = 3'h5,
        TMR8_WGM_RSV6 = 3'h6,
        TMR8_WGM_FAST_OCA = 3'h7
    } tmr8_wgm_e;

    // Control register A layout
    typedef struct packed {
        logic [1:0] out_mode_a_field;
        logic [1:0] out_mode_b_field;
        logic [1:0] rsvd;
        logic [1:0] wave_mode_low;
    } tmr8_ctrl_a_s;

    // Waveform pin group
    typedef struct packed {
        logic wave_out_a_pin;
        logic wave_out_a_oe;
        logic wave_out_b_pin;
        logic wave_out_b_oe;
    } tmr8_wave_s;
endpackage

// ===== tb/tmr8_ctrl_props.sv
// Port checker for the 8-bit timer control block
`timescale 1ns/1ns
module tmr8_ctrl_props
    import tmr8_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] vector_ack,
    input wire tmr8_wave_s wave_out,
    input wire logic [2:0] irq_req
);
    logic ap_r;
    logic aw_r;
    logic [7:0] aa_r;
    logic [7:0] ca_r;
    logic [2:0] cs_r;
    logic [2:0] en_r;
    logic gl_r;
    logic wr;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase tracking; a write acts at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_r <= 1'b0;
            aw_r <= 1'b0;
            aa_r <= 8'h00;
        end
        else
        begin
            ap_r <= hsel && hready && htrans == TMR8_HTRANS_NONSEQ;
            aw_r <= hwrite && hsize == TMR8_HSIZE_WORD
                && haddr[31:8] == 24'h000000;
            aa_r <= haddr[7:0];
        end
    end
    assign wr = ap_r && aw_r;
    // Shadow of the settings that decide what the outputs may do
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ca_r <= 8'h00;
            cs_r <= 3'h0;
            en_r <= 3'h0;
            gl_r <= 1'b0;
        end
        else if (wr && aa_r == TMR8_OFS_CTRL_A)
            ca_r <= hwdata[7:0];
        else if (wr && aa_r == TMR8_OFS_CTRL_B)
            cs_r <= hwdata[2:0];
        else if (wr && aa_r == TMR8_OFS_IRQ_EN)
            en_r <= hwdata[2:0];
        else if (wr && aa_r == TMR8_OFS_GLOBAL)
            gl_r <= hwdata[0];
    end
    // Control B write while stopped; kept stopped so no match can interfere
    sequence s_force;
        wr && aa_r == TMR8_OFS_CTRL_B && cs_r == 3'h0
            && hwdata[2:0] == 3'h0 && vector_ack == 3'h0;
    endsequence
    sequence s_nonpwm;
        !hwdata[TMR8_WGM_HI_BIT] && !ca_r[0];
    endsequence
    force_pin_a: assert property (s_force ##0 s_nonpwm
        ##0 (hwdata[7] && ca_r[7]) |=> wave_out.wave_out_a_pin == ca_r[6])
        else $error("forced compare A gave wrong pin level");
    pwm_force_a: assert property (s_force ##0 (hwdata[7:6] != 2'h0
        && !hwdata[TMR8_WGM_HI_BIT] && ca_r[0]) |=> $stable(wave_out))
        else $error("forced compare acted in a PWM mode");
    force_noirq_a: assert property (s_force ##0 (hwdata[7:6] != 2'h0)
        |=> $stable(irq_req))
        else $error("forced compare changed interrupt requests");
    stop_pins_a: assert property (cs_r == 3'h0
        && !(wr && aa_r == TMR8_OFS_CTRL_B)
        |=> $stable({wave_out.wave_out_a_pin, wave_out.wave_out_b_pin}))
        else $error("pins moved with the counter stopped");
    irq_gate_a: assert property ((irq_req & ~en_r) == 3'h0
        && (gl_r || irq_req == 3'h0))
        else $error("request without its enable or global enable");
    vector_clr_a: assert property (vector_ack != 3'h0
        && cs_r == 3'h0 |=> (irq_req & $past(vector_ack)) == 3'h0)
        else $error("vector acknowledge left request pending");
    ctlb_rsvd_a: assert property (ap_r
        && aa_r == TMR8_OFS_CTRL_B |-> hrdata[31:4] == 28'h0)
        else $error("control B strobe or reserved bits read nonzero");
    irq_rsvd_a: assert property (ap_r && (aa_r == TMR8_OFS_IRQ_EN
        || aa_r == TMR8_OFS_IRQ_FLG) |-> hrdata[31:3] == 29'h0)
        else $error("enable or flag reserved bits read nonzero");
    idle_rdata_a: assert property (!ap_r |-> hrdata == 32'h0)
        else $error("read data outside a data phase");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
endmodule
bind tmr8_ctrl tmr8_ctrl_props i_props (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .vector_ack, .wave_out, .irq_req);

// ===== tb/tmr8_ctrl_tb.sv
// Self-checking testbench for the 8-bit timer control block
`timescale 1ns/1ns
module tmr8_ctrl_tb
    import tmr8_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic count_input_pin = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [2:0] vector_ack = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd_q;
    logic [31:0] r;
    logic [31:0] s;
    logic hreadyout;
    logic hresp;
    logic hready;
    tmr8_wave_s wave_out;
    logic [2:0] irq_req;
    int fail_count = 0;
    int check_count = 0;
    int divs [5] = '{1, 8, 64, 256, 1024};
    // Rows: address, written byte, byte read back
    logic [23:0] rows [10] = '{24'h00F2F2, 24'h0CA5A5, 24'h105A5A,
        24'h14FF07, 24'h1CFF01, 24'h083C3C, 24'h04C808, 24'h043000,
        24'h18FF00, 24'h205A00};

    always #10 hclk = ~hclk;
    assign hready = hreadyout;
    // Read data captured at the edge that closes the data phase
    always @(posedge hclk) rd_q <= hrdata;

    tmr8_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .count_input_pin(count_input_pin), .vector_ack(vector_ack),
        .wave_out(wave_out), .irq_req(irq_req));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for ready; a hang ends the run
    task automatic wrdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            fail_count++;
            finish_test();
        end
    endtask

    // One single word transfer; read data lands in r
    task automatic bus(input logic wt, input logic [7:0] a,
        input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= TMR8_HTRANS_NONSEQ;
        hwrite <= wt;
        hsize <= TMR8_HSIZE_WORD;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wrdy();
        #1;
        r = rd_q;
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask

    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd(8'(4 * i));
            chk("reset value", 32'h0, r);
        end
        foreach (rows[i])
        begin
            w(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            s = {24'h0, rows[i][7:0]};
            chk("readback", s, r);
        end
        $display("register table done");
        // Each tap gives 20 ticks over 20 of its periods, then holds
        foreach (divs[k])
        begin
            w(TMR8_OFS_COUNT, 8'h00);
            w(TMR8_OFS_CTRL_B, 8'(k + 1));
            repeat (20 * divs[k] - 2) @(posedge hclk);
            w(TMR8_OFS_CTRL_B, 8'h00);
            rd(TMR8_OFS_COUNT);
            chk("ticks", 32'h1, 32'(r inside {[19:21]}));
        end
        s = r;
        repeat (30) @(posedge hclk);
        rd(TMR8_OFS_COUNT);
        chk("stopped", s, r);
        $display("prescaler done");
        // Five pulses on the count input, falling then rising select
        for (int m = 6; m < 8; m++)
        begin
            w(TMR8_OFS_COUNT, 8'h00);
            w(TMR8_OFS_CTRL_B, 8'(m));
            repeat (5)
            begin
                count_input_pin <= 1'b1;
                repeat (2) @(posedge hclk);
                count_input_pin <= 1'b0;
                repeat (2) @(posedge hclk);
            end
            w(TMR8_OFS_CTRL_B, 8'h00);
            rd(TMR8_OFS_COUNT);
            chk("edges", 32'h5, r);
        end
        $display("external clock done");
        // Matches on both channels, overflow, flag clearing, masking
        w(TMR8_OFS_CTRL_A, 8'hD0);
        w(TMR8_OFS_CMP_A, 8'h05);
        w(TMR8_OFS_CMP_B, 8'h06);
        w(TMR8_OFS_IRQ_FLG, 8'h07);
        w(TMR8_OFS_COUNT, 8'h00);
        w(TMR8_OFS_CTRL_B, 8'h01);
        repeat (10) @(posedge hclk);
        w(TMR8_OFS_CTRL_B, 8'h00);
        rd(TMR8_OFS_IRQ_FLG);
        chk("match flags", 32'h6, r);
        chk("irq", 32'h6, 32'(irq_req));
        chk("wave", 32'hD, 32'(wave_out));
        w(TMR8_OFS_COUNT, 8'hFE);
        w(TMR8_OFS_CTRL_B, 8'h01);
        repeat (3) @(posedge hclk);
        w(TMR8_OFS_CTRL_B, 8'h00);
        w(TMR8_OFS_IRQ_FLG, 8'h02);
        rd(TMR8_OFS_IRQ_FLG);
        chk("overflow w1c", 32'h5, r);
        vector_ack <= 3'h1;
        @(posedge hclk);
        vector_ack <= 3'h0;
        rd(TMR8_OFS_IRQ_FLG);
        chk("vector clear", 32'h4, r);
        chk("irq", 32'h4, 32'(irq_req));
        w(TMR8_OFS_GLOBAL, 8'h00);
        chk("irq global off", 32'h0, 32'(irq_req));
        w(TMR8_OFS_GLOBAL, 8'h01);
        w(TMR8_OFS_IRQ_EN, 8'h03);
        chk("irq masked", 32'h0, 32'(irq_req));
        $display("flags done");
        // Count write blocks only the first tick: A at 05 missed, B at 06
        w(TMR8_OFS_IRQ_FLG, 8'h07);
        w(TMR8_OFS_COUNT, 8'h05);
        w(TMR8_OFS_CTRL_B, 8'h01);
        w(TMR8_OFS_CTRL_B, 8'h00);
        rd(TMR8_OFS_IRQ_FLG);
        chk("blocked match", 32'h4, r);
        chk("wave", 32'hF, 32'(wave_out));
        $display("count write done");
        // Forced compares: act in normal mode, set no flag, none in PWM
        w(TMR8_OFS_IRQ_FLG, 8'h07);
        w(TMR8_OFS_CTRL_A, 8'h80);
        w(TMR8_OFS_CTRL_B, 8'hC0);
        chk("force clear", 32'h6, 32'(wave_out));
        rd(TMR8_OFS_IRQ_FLG);
        chk("force flags", 32'h0, r);
        w(TMR8_OFS_CTRL_A, 8'hF3);
        w(TMR8_OFS_CTRL_B, 8'hC0);
        chk("force pwm", 32'h7, 32'(wave_out));
        w(TMR8_OFS_CTRL_A, 8'h10);
        w(TMR8_OFS_CTRL_B, 8'h40);
        chk("force toggle", 32'h1, 32'(wave_out));
        $display("force done");
        // Fast PWM with compare A as top wraps there and flags overflow
        w(TMR8_OFS_CTRL_A, 8'h03);
        w(TMR8_OFS_CMP_A, 8'h03);
        w(TMR8_OFS_IRQ_FLG, 8'h07);
        w(TMR8_OFS_COUNT, 8'h00);
        w(TMR8_OFS_CTRL_B, 8'h09);
        repeat (2) @(posedge hclk);
        w(TMR8_OFS_CTRL_B, 8'h08);
        rd(TMR8_OFS_IRQ_FLG);
        chk("top flags", 32'h3, r);
        rd(TMR8_OFS_COUNT);
        chk("top wrap", 32'h0, r);
        $display("top mode done");
        // Reset in mid-run drops pins, requests and registers
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("reset outs", 32'h0, 32'({wave_out, irq_req}));
        hresetn <= 1'b1;
        rd(TMR8_OFS_CMP_A);
        chk("reset compare", 32'h0, r);
        $display("reset done");
        finish_test();
    end
endmodule
